// File: src/ddr_mode_pkg.sv
/*
  Package for the DDR mode-register programming block: command pin bundle,
  mode fields, decoded settings and field positions.
  Assumes the command pins are sampled as levels from the link clock domain.
*/
package ddr_mode_pkg;

  localparam int ADDR_W = 12;
  // Mode register field positions.
  localparam int BL_LO = 0;
  localparam int BL_HI = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LO = 4;
  localparam int CL_HI = 6;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  // Extended mode register field positions.
  localparam int DLLDIS_BIT = 0;
  localparam int DRV_BIT = 1;
  // Burst length and latency codes.
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_25 = 3'h6;
  // Reset value of captured registers; contents are undefined at power-up.
  localparam logic [ADDR_W-1:0] MR_RESET = 12'h000;
  localparam logic EMR_BA1_RESET = 1'b0;
  // Write completion time in link clocks.
  localparam logic [1:0] WRITE_CYCLES = 2'h2;

  typedef enum logic [1:0] {BL_NONE, BL_2, BL_4, BL_8} burst_len_e;
  typedef enum logic [1:0] {CL_NONE, CL_2, CL_25} cas_lat_e;

  // Command and address pins as sampled.
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic ba1;
    logic ba0;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_s;

  // Decoded operating settings.
  typedef struct packed {
    burst_len_e burstLen;
    logic burstOrderSelect;
    cas_lat_e casLat;
    logic testModeBit;
    logic dllEnable;
    logic weakDrive;
  } mode_cfg_s;

endpackage

// File: src/ddr_mode_register.sv
/*
  DDR mode and extended mode register programming logic with burst address
  ordering. The link clock is sampled by mclk (200 MHz) and its rising edges
  found; pins pass a three-stage synchroniser. The controller is assumed to
  keep the precharge, spacing and field-value obligations of the protocol.
*/
`timescale 1ns/1ps
`default_nettype none

module ddr_mode_register (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // Link pins
  input wire logic linkClk,
  input wire logic linkCke,
  input wire ddr_mode_pkg::cmd_pins_s cmdPins,
  input wire logic selfRefreshExit,
  // Burst address request
  input wire logic burstStart,
  input wire logic [2:0] burstStartAddr,
  // Settings and status
  output var ddr_mode_pkg::mode_cfg_s modeCfg,
  output logic [ddr_mode_pkg::ADDR_W-1:0] modeReg,
  output logic [ddr_mode_pkg::ADDR_W-1:0] extModeReg,
  output logic extModeBa1,
  output logic dllResetPulse,
  output logic loadBusy,
  // Burst address sequence
  output logic [2:0] burstAddr,
  output logic burstValid
);

  localparam int SYNC_W = $bits(ddr_mode_pkg::cmd_pins_s) + 3;

  typedef enum logic [1:0] {IDLE, BURST} burst_state_e;

  // Burst length in beats from the decoded setting.
  function automatic logic [3:0] beatsOf(input ddr_mode_pkg::burst_len_e bl);
    logic [3:0] n;
    n = 4'h0;
    unique case (bl)
      ddr_mode_pkg::BL_2: n = 4'h2;
      ddr_mode_pkg::BL_4: n = 4'h4;
      ddr_mode_pkg::BL_8: n = 4'h8;
      ddr_mode_pkg::BL_NONE: n = 4'h0;
    endcase
    return n;
  endfunction

  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
  logic [SYNC_W-1:0] sync1_d, sync2_d, sync3_d;
  ddr_mode_pkg::cmd_pins_s pins;
  logic clkSeen, ckeSeen, srxSeen, linkRise, srxRise;
  logic clkPrev_q, clkPrev_d, srxPrev_q, srxPrev_d;
  logic [ddr_mode_pkg::ADDR_W-1:0] mr_q, mr_d, emr_q, emr_d;
  logic ba1_q, ba1_d, dllRst_q, dllRst_d, dllDis_q, dllDis_d;
  logic [1:0] busy_q, busy_d;
  logic isMrs, isEmrs;
  burst_state_e bst_q, bst_d;
  logic [2:0] start_q, start_d, beat_q, beat_d, addr_q, addr_d;
  logic [3:0] beats;
  logic [2:0] mask, nextBeat;

  // Three-stage synchroniser; only stages two and three are looked at.
  always_comb
  begin
    sync1_d = {linkClk, linkCke, selfRefreshExit, cmdPins};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else if (clkEn)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  // The link clock and self refresh exit pins count as changed only once stages two and three agree.
  always_comb
  begin
    pins = sync3_q[SYNC_W-4:0];
    clkSeen = (sync2_q[SYNC_W-1] == sync3_q[SYNC_W-1]) ? sync3_q[SYNC_W-1] : clkPrev_q;
    ckeSeen = sync3_q[SYNC_W-2];
    srxSeen = (sync2_q[SYNC_W-3] == sync3_q[SYNC_W-3]) ? sync3_q[SYNC_W-3] : srxPrev_q;
    linkRise = clkSeen && !clkPrev_q;
    srxRise = srxSeen && !srxPrev_q;
    clkPrev_d = clkSeen;
    srxPrev_d = srxSeen;
  end

  // Command decode on each link rising edge. Pins are taken from the same third stage as the
  // clock, and the controller changes them far inside the 125 ns link period, so the command is stable.
  always_comb
  begin
    isMrs = linkRise && ckeSeen && !pins.csN && !pins.rasN && !pins.casN && !pins.weN && !pins.ba0;
    isEmrs = linkRise && ckeSeen && !pins.csN && !pins.rasN && !pins.casN && !pins.weN && pins.ba0;
  end

  // Register capture. Banks-precharged is the controller's duty, so loads are
  // taken whenever decoded, including during operation.
  always_comb
  begin
    mr_d = mr_q;
    emr_d = emr_q;
    ba1_d = ba1_q;
    dllRst_d = 1'b0;
    dllDis_d = dllDis_q;
    busy_d = busy_q;
    if (linkRise && busy_q != 2'h0)
      busy_d = busy_q - 2'h1;
    if (isMrs)
    begin
      mr_d = pins.addr;
      dllRst_d = pins.addr[ddr_mode_pkg::DLLRST_BIT];
      busy_d = ddr_mode_pkg::WRITE_CYCLES;
    end
    if (isEmrs)
    begin
      emr_d = pins.addr;
      ba1_d = pins.ba1;
      dllDis_d = pins.addr[ddr_mode_pkg::DLLDIS_BIT];
      busy_d = ddr_mode_pkg::WRITE_CYCLES;
    end
    // DLL on at self refresh exit
    if (srxRise)
      dllDis_d = 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mr_q <= ddr_mode_pkg::MR_RESET;
      emr_q <= ddr_mode_pkg::MR_RESET;
      ba1_q <= ddr_mode_pkg::EMR_BA1_RESET;
      dllRst_q <= 1'b0;
      dllDis_q <= 1'b0;
      busy_q <= 2'h0;
      clkPrev_q <= 1'b0;
      srxPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      mr_q <= mr_d;
      emr_q <= emr_d;
      ba1_q <= ba1_d;
      dllRst_q <= dllRst_d;
      dllDis_q <= dllDis_d;
      busy_q <= busy_d;
      clkPrev_q <= clkPrev_d;
      srxPrev_q <= srxPrev_d;
    end
  end

  // Field decode; reserved codes decode to NONE and are not acted on.
  always_comb
  begin
    unique case (mr_q[ddr_mode_pkg::BL_HI:ddr_mode_pkg::BL_LO])
      ddr_mode_pkg::BL_CODE_2: modeCfg.burstLen = ddr_mode_pkg::BL_2;
      ddr_mode_pkg::BL_CODE_4: modeCfg.burstLen = ddr_mode_pkg::BL_4;
      ddr_mode_pkg::BL_CODE_8: modeCfg.burstLen = ddr_mode_pkg::BL_8;
      default: modeCfg.burstLen = ddr_mode_pkg::BL_NONE;
    endcase
    modeCfg.burstOrderSelect = mr_q[ddr_mode_pkg::BT_BIT];
    unique case (mr_q[ddr_mode_pkg::CL_HI:ddr_mode_pkg::CL_LO])
      ddr_mode_pkg::CL_CODE_2: modeCfg.casLat = ddr_mode_pkg::CL_2;
      ddr_mode_pkg::CL_CODE_25: modeCfg.casLat = ddr_mode_pkg::CL_25;
      default: modeCfg.casLat = ddr_mode_pkg::CL_NONE;
    endcase
    modeCfg.testModeBit = mr_q[ddr_mode_pkg::TM_BIT];
    modeCfg.dllEnable = !dllDis_q;
    modeCfg.weakDrive = emr_q[ddr_mode_pkg::DRV_BIT];
  end

  // Status outputs from flip-flops; loadBusy is decoded from the busy count.
  assign modeReg = mr_q;
  assign extModeReg = emr_q;
  assign extModeBa1 = ba1_q;
  assign dllResetPulse = dllRst_q;
  assign loadBusy = (busy_q != 2'h0);

  // Burst address generator, one beat per link rising edge.
  always_comb
  begin
    beats = beatsOf(modeCfg.burstLen);
    mask = 3'(beats - 4'h1);
    bst_d = bst_q;
    start_d = start_q;
    beat_d = beat_q;
    addr_d = addr_q;
    nextBeat = beat_q + 3'h1;
    unique case (bst_q)
      IDLE:
      begin
        if (burstStart && beats != 4'h0)
        begin
          start_d = burstStartAddr;
          beat_d = 3'h0;
          addr_d = burstStartAddr;
          bst_d = BURST;
        end
      end
      BURST:
      begin
        if (linkRise)
        begin
          if ({1'b0, nextBeat} == beats || nextBeat == 3'h0)
            bst_d = IDLE;
          else
          begin
            beat_d = nextBeat;
            if (modeCfg.burstOrderSelect)
              addr_d = start_q ^ nextBeat;
            else
              addr_d = (start_q & ~mask) | ((start_q + nextBeat) & mask);
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      bst_q <= IDLE;
      start_q <= 3'h0;
      beat_q <= 3'h0;
      addr_q <= 3'h0;
    end
    else if (clkEn)
    begin
      bst_q <= bst_d;
      start_q <= start_d;
      beat_q <= beat_d;
      addr_q <= addr_d;
    end
  end

  assign burstAddr = addr_q;
  assign burstValid = (bst_q == BURST);

endmodule

`default_nettype wire

// File: tb/ddr_ctrl_model.sv
/* Controller model: runs the link clock and issues commands.
   Assumes the bench calls ld() one command at a time. */
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
  // Link pins
  output logic linkClk,
  output logic linkCke,
  output var ddr_mode_pkg::cmd_pins_s cmdPins
);
  // Offset keeps link edges off mclk edges.
  initial
  begin
    linkClk = 1'b0;
    linkCke = 1'b0;
    cmdPins = '1;
    #1.2;
    forever #62.5 linkClk = ~linkClk;
  end
  // clock enable first; no bank is ever opened, so all stay precharged.
  initial repeat (4) @(negedge linkClk) linkCke <= 1'b1;
  task ckeSet(input logic v);
    @(negedge linkClk) linkCke <= v;
  endtask
  // two idle clocks; a deselected bus shows the inverse address.
  task ld(input logic [3:0] cmd, input logic b1, input logic b0, input logic [11:0] a);
    @(negedge linkClk) cmdPins <= {cmd, b1, b0, a};
    @(negedge linkClk) cmdPins <= {4'hf, ~b1, ~b0, ~a};
    repeat (2) @(negedge linkClk);
  endtask
endmodule
`default_nettype wire

// File: tb/ddr_mode_register_asserts.sv
/* Checker on the ports of ddr_mode_register.
   Assumes clkEn stays high, so every mclk edge advances. */
`timescale 1ns/1ps
`default_nettype none
module ddr_mode_register_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Inputs
  input wire logic selfRefreshExit,
  input wire logic burstStart,
  input wire logic [2:0] burstStartAddr,
  // Outputs
  input wire ddr_mode_pkg::mode_cfg_s modeCfg,
  input wire logic [11:0] modeReg,
  input wire logic [11:0] extModeReg,
  input wire logic dllResetPulse,
  input wire logic loadBusy,
  input wire logic [2:0] burstAddr,
  input wire logic burstValid
);
  // One domain, so clock and reset are given once.
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Burst length codes equal the enum values, so the low bits map across.
  property p_bl;
    modeCfg.burstLen == (modeReg[2] ? 2'h0 : modeReg[1:0]);
  endproperty
  a_bl: assert property (p_bl) else $error("burst length decode wrong");
  property p_cl;
    modeCfg.casLat == (modeReg[6:4] == 3'h2 ? 2'h1 : modeReg[6:4] == 3'h6 ? 2'h2 : 2'h0);
  endproperty
  a_cl: assert property (p_cl) else $error("latency decode wrong");
  property p_bt;
    modeCfg.burstOrderSelect == modeReg[3];
  endproperty
  a_bt: assert property (p_bt) else $error("burst order wrong");
  property p_rst;
    dllResetPulse |-> modeReg[8] ##1 !dllResetPulse;
  endproperty
  a_rst: assert property (p_rst) else $error("DLL reset pulse wrong");
  property p_drv;
    modeCfg.weakDrive == extModeReg[1];
  endproperty
  a_drv: assert property (p_drv) else $error("drive select wrong");
  property p_sre;
    $rose(selfRefreshExit) |-> ##[1:8] modeCfg.dllEnable;
  endproperty
  a_sre: assert property (p_sre) else $error("DLL not re-enabled");
  property p_start;
    burstStart && !burstValid && modeCfg.burstLen != ddr_mode_pkg::BL_NONE |=>
      burstValid && burstAddr == $past(burstStartAddr);
  endproperty
  a_start: assert property (p_start) else $error("burst start wrong");
  property p_seq;
    burstValid && $past(burstValid) && $changed(burstAddr) && !modeCfg.burstOrderSelect &&
      modeCfg.burstLen == ddr_mode_pkg::BL_4 |-> burstAddr == {$past(burstAddr[2]), $past(burstAddr[1:0]) + 2'h1};
  endproperty
  a_seq: assert property (p_seq) else $error("sequential step wrong");
  property p_cap;
    $changed(modeReg) |-> $rose(loadBusy);
  endproperty
  a_cap: assert property (p_cap) else $error("mode register changed outside a load");
endmodule
bind ddr_mode_register ddr_mode_register_chk i_chk (.mclk, .reset, .selfRefreshExit, .burstStart,
  .burstStartAddr, .modeCfg, .modeReg, .extModeReg, .dllResetPulse, .loadBusy, .burstAddr, .burstValid);
`default_nettype wire

// File: tb/testbench.sv
/* Self-checking bench for ddr_mode_register with a controller model.
   Assumes registers read zero after reset. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic selfRefreshExit = 1'b0;
  logic burstStart = 1'b0;
  logic [2:0] burstStartAddr = 3'h0;
  wire logic linkClk;
  wire logic linkCke;
  wire ddr_mode_pkg::cmd_pins_s cmdPins;
  ddr_mode_pkg::mode_cfg_s modeCfg;
  logic [11:0] modeReg;
  logic [11:0] extModeReg;
  logic extModeBa1, dllResetPulse, loadBusy, burstValid;
  logic [2:0] burstAddr;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 32'h3026dab0;
  int mr = 0, emr = 0, eb1 = 0, dll = 1, rstCnt = 0, i, n;
  // Clock and pulse counter.
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (dllResetPulse === 1'b1) rstCnt++;
  ddr_ctrl_model i_ddr_ctrl_model (.linkClk, .linkCke, .cmdPins);
  ddr_mode_register i_ddr_mode_register (.mclk, .reset, .clkEn, .linkClk, .linkCke, .cmdPins,
    .selfRefreshExit, .burstStart, .burstStartAddr, .modeCfg, .modeReg, .extModeReg, .extModeBa1,
    .dllResetPulse, .loadBusy, .burstAddr, .burstValid);
  task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chkAll(input string t);
    chk("mr", modeReg, mr);
    chk("emr", extModeReg, emr);
    chk("ba1", extModeBa1, eb1);
    chk("bl", modeCfg.burstLen, mr[2] ? 0 : mr[1:0]);
    chk("cl", modeCfg.casLat, mr[6:4] == 2 ? 1 : mr[6:4] == 6 ? 2 : 0);
    chk("bt", modeCfg.burstOrderSelect, mr[3]);
    chk("tm", modeCfg.testModeBit, mr[7]);
    chk("busy", loadBusy, 0);
    chk("dll", modeCfg.dllEnable, dll);
    chk("drv", modeCfg.weakDrive, emr[1]);
    $display("done: %s", t);
  endtask
  task mrs(input logic [11:0] a);
    i_ddr_ctrl_model.ld(4'h0, 1'b0, 1'b0, a);
    mr = a;
  endtask
  task emrs(input logic b1, input logic [11:0] a);
    i_ddr_ctrl_model.ld(4'h0, b1, 1'b1, a);
    emr = a;
    eb1 = b1;
    dll = !a[0];
  endtask
  // Expected beats are queued from the ordering rules; a beat is seen when the address moves.
  // Every cycle is sampled, since a link edge right after the start can make the first beat short.
  task burst(input logic [2:0] s);
    int bl, k, e, prev;
    int q[$];
    bl = 1 << mr[1:0];
    for (k = 0; k < bl; k++)
    begin
      e = mr[3] ? s ^ k : (s & ~(bl - 1)) | ((s + k) & (bl - 1));
      q.push_back(e & 7);
    end
    n = 0;
    prev = 0;
    @(posedge mclk) {burstStart, burstStartAddr} <= {1'b1, s};
    @(posedge mclk) burstStart <= 1'b0;
    for (k = 0; k < 800 && !(n > 0 && burstValid !== 1'b1); k++)
    begin
      #1;
      if (burstValid === 1'b1 && (n == 0 || burstAddr !== 3'(prev)))
      begin
        e = (q.size() > 0) ? q.pop_front() : 8;
        chk("beat", burstAddr, 12'(e));
        prev = burstAddr;
        n++;
      end
      @(posedge mclk);
    end
    chk("beats", n, bl);
    $display("done: burst of %0d", bl);
    if (k == 800)
    begin
      mismatches++;
      tally_and_finish;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    // No burst is taken while the length decodes to none after reset.
    @(posedge mclk) burstStart <= 1'b1;
    @(posedge mclk) burstStart <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("refuse", burstValid, 0);
    $display("done: refuse");
    emrs(1'b0, 12'h000);
    chkAll("dll enable");
    emrs(1'b1, 12'h002);
    chkAll("weak drive");
    n = rstCnt;
    mrs(12'h122);
    chk("rst", rstCnt - n, 1);
    chkAll("dll reset");
    repeat (200) @(negedge linkClk);
    i = rstCnt;
    // reprogram every legal mode with test mode low.
    for (int j = 0; j < 12; j++)
    begin
      mrs({5'h00, (j[0] ? 3'h6 : 3'h2), j[1], 1'b0, 2'(j / 4 + 1)});
      chkAll("mode");
      burst(3'($random(seed)));
    end
    chk("norst", rstCnt, i);
    // legal codes only: length 8, interleaved, latency 2.5.
    mrs(12'h06b);
    chkAll("late mode");
    i_ddr_ctrl_model.ld(4'h1, 1'b0, 1'b0, 12'($random(seed)));
    chkAll("other command");
    i_ddr_ctrl_model.ckeSet(1'b0);
    i_ddr_ctrl_model.ld(4'h0, 1'b0, 1'b0, 12'h022);
    chkAll("cke low");
    i_ddr_ctrl_model.ckeSet(1'b1);
    emrs(1'b0, 12'h001);
    chkAll("dll off");
    @(posedge mclk) selfRefreshExit <= 1'b1;
    repeat (8) @(posedge mclk);
    dll = 1;
    chkAll("self refresh exit");
    tally_and_finish;
  end
endmodule
`default_nettype wire
